// File: hw/pbc_top.sv
// Four-bit presettable binary up/down counter with cascade carry pins.
// Assumes every pin input is synchronous to aclk; the count clock pin is
// sampled and its rising edge detected, and AXI4-Lite reaches the registers.
//
// Overview of operation
// - Carry input high blocks counting; the count holds.
// - Count steps only on a rising edge of the count clock.
// - Direction high counts up, low counts down.
// - Load enable high copies the four load bits into the count.
// - Clear high zeroes the count and beats every other input.
// - Count bits are plain binary, bit zero least significant.
// - Counting up, carry out is low only at fifteen with carry in low.
// - Counting down, carry out is low only at zero with carry in low.
// - Carry out is active low and registered with the count.
// - Cascaded, carry out stays low one whole count clock period.
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
module pbc_top
   import pbc_pkg::*;
#(
   parameter int STEP_W = 16
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic count_clock,
   input wire logic count_up,
   input wire logic carry_in_n,
   input wire logic parallel_load_enable,
   input wire logic load_value_bit0,
   input wire logic load_value_bit1,
   input wire logic load_value_bit2,
   input wire logic load_value_bit3,
   input wire logic clear,
   output logic count_bit0,
   output logic count_bit1,
   output logic count_bit2,
   output logic count_bit3,
   output logic carry_out_n,
   input wire logic [AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [AXI_DW-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [AXI_DW-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   pbc_count_t count;
   pbc_count_t next_count;
   pbc_count_t load_pins;
   pbc_count_t load_reg;
   logic next_carry_out_n;
   logic ctrl_gate;
   logic clk_rise;
   logic step;
   logic sw_clear;
   logic sw_load;
   logic clr_any;
   logic ld_any;
   logic ctrl_wr;
   logic [STEP_W-1:0] steps;

   pbc_reg_if ifc();

   // Address map check, shared by the write and read paths
   function automatic logic addr_ok(input logic [AXI_AW-1:0] addr);
      addr_ok = (addr == REG_CTRL) || (addr == REG_LOAD) ||
                (addr == REG_STATUS) || (addr == REG_STEPS);
   endfunction

   // Terminal count for the selected direction
   function automatic logic at_terminal(input pbc_count_t value, input logic up);
      at_terminal = up ? (value == CNT_MAX) : (value == CNT_MIN);
   endfunction

   pbc_axil u_axil
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .clk_en(clk_en),
      .awaddr(s_axi_awaddr),
      .awvalid(s_axi_awvalid),
      .awready(s_axi_awready),
      .wdata(s_axi_wdata),
      .wstrb(s_axi_wstrb),
      .wvalid(s_axi_wvalid),
      .wready(s_axi_wready),
      .bresp(s_axi_bresp),
      .bvalid(s_axi_bvalid),
      .bready(s_axi_bready),
      .araddr(s_axi_araddr),
      .arvalid(s_axi_arvalid),
      .arready(s_axi_arready),
      .rdata(s_axi_rdata),
      .rresp(s_axi_rresp),
      .rvalid(s_axi_rvalid),
      .rready(s_axi_rready),
      .regs(ifc)
   );

   pbc_edge u_edge
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .clk_en(clk_en),
      .level(count_clock),
      .rise(clk_rise)
   );

   // Load pins gathered, bit zero least significant
   assign load_pins = {load_value_bit3, load_value_bit2, load_value_bit1, load_value_bit0};

   // Software pulses act in the same cycle as the bus write
   assign ctrl_wr = ifc.wr_en && (ifc.wr_addr == REG_CTRL) && ifc.wr_strb[0];
   assign sw_clear = ctrl_wr && ifc.wr_data[CTRL_CLEAR_BIT];
   assign sw_load = ctrl_wr && ifc.wr_data[CTRL_LOAD_BIT];
   assign clr_any = clear | sw_clear;
   assign ld_any = parallel_load_enable | sw_load;

   assign step = clk_rise & ~carry_in_n & ctrl_gate;

   // Clear, then load, then count; one edge of latency replaces async action
   always_comb
   begin
      next_count = count;
      if (clr_any)
         next_count = CNT_MIN;
      else if (parallel_load_enable)
         next_count = load_pins;
      else if (sw_load)
         next_count = load_reg;
      else if (step)
         next_count = count_up ? count + CNT_ONE : count - CNT_ONE;
   end

   assign next_carry_out_n = ~(~carry_in_n & at_terminal(next_count, count_up));

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         count <= COUNT_RST;
         carry_out_n <= CARRY_N_RST;
      end
      else if (clk_en)
      begin
         count <= next_count;
         carry_out_n <= next_carry_out_n;
      end
   end

   assign count_bit0 = count[0];
   assign count_bit1 = count[1];
   assign count_bit2 = count[2];
   assign count_bit3 = count[3];

   // Control and load registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_gate <= CTRL_GATE_RST;
         load_reg <= LOAD_RST;
      end
      else if (clk_en && ifc.wr_en && ifc.wr_strb[0])
      begin
         if (ifc.wr_addr == REG_CTRL)
            ctrl_gate <= ifc.wr_data[CTRL_GATE_BIT];
         if (ifc.wr_addr == REG_LOAD)
            load_reg <= ifc.wr_data[3:0];
      end
   end

   // Step counter; a step in a clearing or loading cycle does not count
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         steps <= '0;
      else if (clk_en)
      begin
         if (ifc.wr_en && (ifc.wr_addr == REG_STEPS))
            steps <= (step && !clr_any && !ld_any) ? {{(STEP_W-1){1'h0}}, 1'h1} : '0;
         else if (step && !clr_any && !ld_any)
            steps <= steps + 1'h1;
      end
   end

   // Read mux; unmapped offsets read zero with an error response
   always_comb
   begin
      ifc.rd_data = '0;
      ifc.rd_ok = addr_ok(ifc.rd_addr);
      ifc.wr_ok = addr_ok(ifc.wr_addr);
      unique case (ifc.rd_addr)
         REG_CTRL:
            ifc.rd_data[CTRL_GATE_BIT] = ctrl_gate;
         REG_LOAD:
            ifc.rd_data[3:0] = load_reg;
         REG_STATUS:
         begin
            ifc.rd_data[3:0] = count;
            ifc.rd_data[STAT_CARRY_BIT] = carry_out_n;
            ifc.rd_data[STAT_UP_BIT] = count_up;
            ifc.rd_data[STAT_CIN_BIT] = carry_in_n;
            ifc.rd_data[STAT_CLR_BIT] = clear;
            ifc.rd_data[STAT_LOADEN_BIT] = parallel_load_enable;
            ifc.rd_data[STAT_GATE_BIT] = ctrl_gate;
         end
         REG_STEPS:
            ifc.rd_data[STEP_W-1:0] = steps;
         default:
            ifc.rd_data = '0;
      endcase
   end

   // Checks on counting, loading and carry behaviour
   default clocking pbc_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   hold_no_carry_a: assert property (clk_en && !clr_any && !ld_any && carry_in_n
      |=> count == $past(count))
      else $error("count moved while carry input was high");

   hold_no_edge_a: assert property (clk_en && !clr_any && !ld_any && !clk_rise
      |=> $stable(count))
      else $error("count moved without a count clock edge");

   step_up_a: assert property (clk_en && !clr_any && !ld_any && step && count_up
      |=> count == pbc_count_t'($past(count) + CNT_ONE))
      else $error("up step gave wrong count");

   step_down_a: assert property (clk_en && !clr_any && !ld_any && step && !count_up
      |=> count == pbc_count_t'($past(count) - CNT_ONE))
      else $error("down step gave wrong count");

   load_pins_a: assert property (clk_en && !clr_any && parallel_load_enable
      |=> count == $past(load_pins))
      else $error("load did not copy the load pins");

   clear_wins_a: assert property (clk_en && clear
      |=> count == CNT_MIN && {count_bit3, count_bit2, count_bit1, count_bit0} == 4'h0)
      else $error("clear did not zero the count");

   carry_up_a: assert property (clk_en && count_up && !carry_in_n && next_count == CNT_MAX
      |=> !carry_out_n)
      else $error("carry out high at up terminal");

   carry_down_a: assert property (clk_en && !count_up && !carry_in_n && next_count == CNT_MIN
      |=> !carry_out_n)
      else $error("carry out high at down terminal");

   carry_cause_a: assert property ($past(clk_en) && !carry_out_n
      |-> $past(!carry_in_n) && at_terminal(count, $past(count_up)))
      else $error("carry out low away from terminal count");

   carry_period_a: assert property (clk_en && step && !clr_any && !ld_any && !carry_out_n
      && count_up == $past(count_up) |=> carry_out_n)
      else $error("carry out stayed low past one step");

   wrap_both_a: assert property (clk_en && !clr_any && !ld_any && step
      && at_terminal(count, count_up) |=> at_terminal(count, !$past(count_up)))
      else $error("count did not wrap modulo sixteen");

   // Main scenarios reached
   up_wrap_c: cover property (clk_en && step && count_up && count == CNT_MAX);
   down_wrap_c: cover property (clk_en && step && !count_up && count == CNT_MIN);
   carry_low_c: cover property (!carry_out_n ##1 carry_out_n);
   sw_load_c: cover property (clk_en && sw_load && !parallel_load_enable);
endmodule

// File: hw/pbc_pkg.sv
// Shared constants for the presettable binary up/down counter block.
// Assumes a single 20 MHz clock domain and an AXI4-Lite register port.
package pbc_pkg;
   // Count word and its fixed values
   typedef logic [3:0] pbc_count_t;
   localparam pbc_count_t CNT_MIN = 4'h0;
   localparam pbc_count_t CNT_MAX = 4'hF;
   localparam pbc_count_t CNT_ONE = 4'h1;
   localparam pbc_count_t COUNT_RST = 4'h0;
   localparam logic CARRY_N_RST = 1'h1;
   localparam logic EDGE_PREV_RST = 1'h1;
   // Register bus geometry
   localparam int AXI_AW = 8;
   localparam int AXI_DW = 32;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_LOAD = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_STEPS = 8'h0C;
   // Control fields and reset values
   localparam int CTRL_GATE_BIT = 0;
   localparam int CTRL_CLEAR_BIT = 1;
   localparam int CTRL_LOAD_BIT = 2;
   localparam logic CTRL_GATE_RST = 1'h1;
   localparam pbc_count_t LOAD_RST = 4'h0;
   // Status fields
   localparam int STAT_CARRY_BIT = 4;
   localparam int STAT_UP_BIT = 5;
   localparam int STAT_CIN_BIT = 6;
   localparam int STAT_CLR_BIT = 7;
   localparam int STAT_LOADEN_BIT = 8;
   localparam int STAT_GATE_BIT = 9;
endpackage

// File: hw/pbc_reg_if.sv
// Register access path between the bus front end and the register file.
// Assumes both ends run on the same clock; all signals are levels.
`timescale 1ns/100ps
interface pbc_reg_if;
   import pbc_pkg::*;
   logic wr_en;
   logic [AXI_AW-1:0] wr_addr;
   logic [AXI_DW-1:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_ok;
   logic [AXI_AW-1:0] rd_addr;
   logic [AXI_DW-1:0] rd_data;
   logic rd_ok;
   modport bus
   (
      output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
      input wr_ok, rd_data, rd_ok
   );
   modport regs
   (
      input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
      output wr_ok, rd_data, rd_ok
   );
endinterface

// File: hw/pbc_edge.sv
// Rising edge detector for the count clock pin.
// Assumes the pin is already synchronous to aclk.
`timescale 1ns/100ps
module pbc_edge
   import pbc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic level,
   output logic rise
);
   logic prev;

   // Held high at reset so a pin stuck high does not count
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         prev <= EDGE_PREV_RST;
      else if (clk_en)
         prev <= level;
   end

   // Low to high seen between two samples
   assign rise = level & ~prev;
endmodule

// File: hw/pbc_axil.sv
// AXI4-Lite slave front end: one read in flight at most; a second write can be taken while a write response waits.
// Assumes a master that keeps valid and payload steady until ready.
`timescale 1ns/100ps
module pbc_axil
   import pbc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic [AXI_AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [AXI_DW-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [AXI_AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [AXI_DW-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   pbc_reg_if.bus regs
);
   logic aw_held;
   logic w_held;
   logic ar_held;
   logic do_write;

   // Address and data are taken independently, in either order
   assign awready = ~aw_held;
   assign wready = ~w_held;
   assign arready = ~ar_held & ~rvalid;
   assign do_write = aw_held & w_held & ~bvalid;
   assign regs.wr_en = do_write & clk_en;

   // Write address capture
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'h0;
         regs.wr_addr <= '0;
      end
      else if (clk_en)
      begin
         if (awvalid && awready)
         begin
            aw_held <= 1'h1;
            regs.wr_addr <= awaddr;
         end
         else if (do_write)
            aw_held <= 1'h0;
      end
   end

   // Write data capture
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held <= 1'h0;
         regs.wr_data <= '0;
         regs.wr_strb <= '0;
      end
      else if (clk_en)
      begin
         if (wvalid && wready)
         begin
            w_held <= 1'h1;
            regs.wr_data <= wdata;
            regs.wr_strb <= wstrb;
         end
         else if (do_write)
            w_held <= 1'h0;
      end
   end

   // Write response raised on the same edge as the register update
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid <= 1'h0;
         bresp <= RESP_OKAY;
      end
      else if (clk_en)
      begin
         if (do_write)
         begin
            bvalid <= 1'h1;
            bresp <= regs.wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (bvalid && bready)
            bvalid <= 1'h0;
      end
   end

   // Read: address held one cycle, then data registered out
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ar_held <= 1'h0;
         rvalid <= 1'h0;
         rdata <= '0;
         rresp <= RESP_OKAY;
         regs.rd_addr <= '0;
      end
      else if (clk_en)
      begin
         if (arvalid && arready)
         begin
            ar_held <= 1'h1;
            regs.rd_addr <= araddr;
         end
         else if (ar_held)
         begin
            ar_held <= 1'h0;
            rvalid <= 1'h1;
            rdata <= regs.rd_data;
            rresp <= regs.rd_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (rvalid && rready)
            rvalid <= 1'h0;
      end
   end
endmodule

// File: sim/pbc_upper_model.sv
// Behavioural upper stage of a two-stage cascade, fed by the lower carry.
// Assumes the shared count clock pin is sampled on aclk as in the lower stage.
`timescale 1ns/100ps
module pbc_upper_model
   import pbc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic count_clock,
   input wire logic count_up,
   input wire logic carry_in_n,
   input wire logic load_en,
   input wire logic [3:0] load_val,
   output pbc_count_t upper_count
);
   logic prev_clock;
   // Same sampled edge as the lower stage, so both stages step together
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         prev_clock <= EDGE_PREV_RST;
         upper_count <= COUNT_RST;
      end
      else
      begin
         prev_clock <= count_clock;
         if (load_en)
            upper_count <= load_val;
         else if (count_clock && !prev_clock && !carry_in_n)
            upper_count <= count_up ? upper_count + CNT_ONE : upper_count - CNT_ONE;
      end
   end
endmodule

// File: sim/pbc_tb.sv
// Self-checking bench: pin tasks, AXI4-Lite master tasks, upper stage model.
// Assumes the counter top and its package; one 20 MHz clock, sync reset.
`timescale 1ns/100ps
module tb
   import pbc_pkg::*;
;
   logic aclk, aresetn, count_clock, count_up, carry_in_n, ple, clear;
   logic [3:0] lv;
   logic q0, q1, q2, q3, carry_out_n;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
   logic rvalid, rready;
   logic [1:0] bresp, rresp, rs;
   logic up_load, ena;
   logic [3:0] up_val;
   pbc_count_t upper_count;
   wire pbc_count_t cnt = {q3, q2, q1, q0};
   int miscompares = 0;
   int cmp_count = 0;
   int cycles = 0;
   int low_cycles = 0;
   logic meas = 1'h0;

   pbc_top dut (.aclk(aclk), .aresetn(aresetn), .clk_en(ena), .count_clock(count_clock),
      .count_up(count_up), .carry_in_n(carry_in_n), .parallel_load_enable(ple),
      .load_value_bit0(lv[0]), .load_value_bit1(lv[1]), .load_value_bit2(lv[2]),
      .load_value_bit3(lv[3]), .clear(clear), .count_bit0(q0), .count_bit1(q1),
      .count_bit2(q2), .count_bit3(q3), .carry_out_n(carry_out_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   pbc_upper_model upper (.aclk(aclk), .aresetn(aresetn), .count_clock(count_clock),
      .count_up(count_up), .carry_in_n(carry_out_n), .load_en(up_load),
      .load_val(up_val), .upper_count(upper_count));

   // Clock and the hang guard
   initial
   begin
      aclk = 1'h0;
      forever #25 aclk = ~aclk;
   end
   always @(posedge aclk)
   begin
      cycles <= cycles + 1;
      if (meas && carry_out_n === 1'h0)
         low_cycles <= low_cycles + 1;
      if (cycles == 3000)
      begin
         miscompares = miscompares + 1;
         give_verdict();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
         miscompares = miscompares + 1;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // One count clock period of three aclk cycles; count visible on return
   task automatic step();
      @(posedge aclk) count_clock <= 1'h0;
      @(posedge aclk) count_clock <= 1'h1;
      @(posedge aclk) #1;
   endtask

   // Pin load held for one sampled cycle, partner stage loaded alongside
   task automatic pin_load(input logic [3:0] v, input logic [3:0] uv);
      @(posedge aclk)
      begin
         ple <= 1'h1;
         lv <= v;
         up_load <= 1'h1;
         up_val <= uv;
      end
      @(posedge aclk)
      begin
         ple <= 1'h0;
         up_load <= 1'h0;
      end
      #1;
   endtask

   // Address and data offered together; bready held until the response
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic got_b;
      got_b = 1'h0;
      @(posedge aclk)
      begin
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'h1;
         wvalid <= 1'h1;
         bready <= 1'h1;
      end
      while (!got_b)
      begin
         @(posedge aclk);
         if (awvalid && awready)
            awvalid <= 1'h0;
         if (wvalid && wready)
            wvalid <= 1'h0;
         if (bvalid)
         begin
            r = bresp;
            bready <= 1'h0;
            got_b = 1'h1;
         end
      end
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic got_r;
      got_r = 1'h0;
      @(posedge aclk)
      begin
         araddr <= a;
         arvalid <= 1'h1;
         rready <= 1'h1;
      end
      while (!got_r)
      begin
         @(posedge aclk);
         if (arvalid && arready)
            arvalid <= 1'h0;
         if (rvalid)
         begin
            d = rdata;
            r = rresp;
            rready <= 1'h0;
            got_r = 1'h1;
         end
      end
   endtask

   // Main sequence; inputs start at rest, reset held for ten cycles
   initial
   begin
      {count_clock, ple, clear, carry_in_n, awvalid, wvalid, bready} = 7'h00;
      {arvalid, rready, up_load} = 3'h0;
      ena = 1'h1;
      count_up = 1'h1;
      lv = 4'h0;
      up_val = 4'h0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hF;
      aresetn = 1'h0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      axi_read(REG_CTRL, rd, rs);
      check(rd, 32'h1);
      axi_read(REG_LOAD, rd, rs);
      check(rd, 32'h0);
      axi_read(REG_STATUS, rd, rs);
      check(rd, 32'h230);
      axi_read(8'h10, rd, rs);
      check(rs, RESP_SLVERR);
      check(rd, 32'h0);
      check({carry_out_n, cnt}, {1'h1, 4'h0});
      $display("test reset done");
      pin_load(4'hE, 4'h0);
      check(cnt, 4'hE);
      meas = 1'h1;
      step();
      check({carry_out_n, cnt}, {1'h0, 4'hF});
      step();
      meas = 1'h0;
      check({carry_out_n, cnt}, {1'h1, 4'h0});
      check(low_cycles, 3);
      check(upper_count, 4'h1);
      pin_load(4'h5, 4'h0);
      check({q3, q2, q1, q0}, 4'h5);
      $display("test up done");
      pin_load(4'hF, 4'h0);
      carry_in_n <= 1'h1;
      step();
      check({carry_out_n, cnt}, {1'h1, 4'hF});
      carry_in_n <= 1'h0;
      count_up <= 1'h0;
      pin_load(4'h1, 4'h0);
      step();
      check({carry_out_n, cnt}, {1'h0, 4'h0});
      step();
      check({carry_out_n, cnt}, {1'h1, 4'hF});
      $display("test down done");
      @(posedge aclk)
      begin
         clear <= 1'h1;
         ple <= 1'h1;
         lv <= 4'h9;
      end
      step();
      check(cnt, 4'h0);
      @(posedge aclk)
      begin
         clear <= 1'h0;
         ple <= 1'h0;
      end
      $display("test clear done");
      count_up <= 1'h1;
      axi_write(REG_LOAD, 32'h7, rs);
      axi_write(REG_CTRL, 32'h5, rs);
      @(posedge aclk) #1;
      check(cnt, 4'h7);
      axi_write(REG_CTRL, 32'h0, rs);
      axi_write(REG_STEPS, 32'h0, rs);
      step();
      check(cnt, 4'h7);
      axi_write(REG_CTRL, 32'h1, rs);
      step();
      check(cnt, 4'h8);
      axi_read(REG_STEPS, rd, rs);
      check(rd, 32'h1);
      axi_write(REG_STATUS, 32'h0, rs);
      check(rs, RESP_OKAY);
      axi_write(8'h14, 32'h0, rs);
      check(rs, RESP_SLVERR);
      axi_write(REG_CTRL, 32'h3, rs);
      @(posedge aclk) #1;
      check(cnt, 4'h0);
      $display("test registers done");
      // Enable low freezes both the count clock edge and the pin load
      @(posedge aclk)
      begin
         ena <= 1'h0;
         ple <= 1'h1;
         lv <= 4'hA;
      end
      step();
      check(cnt, 4'h0);
      @(posedge aclk) ple <= 1'h0;
      @(posedge aclk) ena <= 1'h1;
      @(posedge aclk) #1;
      check(cnt, 4'h0);
      $display("test enable done");
      count_up <= 1'h0;
      // nonzero ratio, both stages counting down
      pin_load(4'h0, 4'h1);
      step();
      check({upper_count, cnt}, 8'h0F);
      $display("test divider done");
      give_verdict();
   end
endmodule
